// ---- src/tdcr_pkg.sv ----
package tdcr_pkg;

  // ----------------
  // Bus geometry
  // ----------------
  localparam int DATA_W = 28;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 4;
  localparam int UPPER_W = DATA_W - HALF_W;

  // ----------------
  // Register offsets
  // ----------------
  localparam logic [ADDR_W-1:0] ADR_GATE = 4'h5;
  localparam logic [ADDR_W-1:0] ADR_FILL = 4'h6;
  localparam logic [ADDR_W-1:0] ADR_LOOP = 4'h7;
  localparam logic [ADDR_W-1:0] ADR_RES1 = 4'h8;
  localparam logic [ADDR_W-1:0] ADR_RES2 = 4'h9;
  localparam logic [ADDR_W-1:0] ADR_GAP  = 4'hA;
  localparam logic [ADDR_W-1:0] ADR_BUS  = 4'hE;

  localparam logic [DATA_W-1:0] REG_RESET = 28'h0000000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 28'h0000000;

  // ----------------
  // Gating and reset source register fields
  // ----------------
  localparam int OFF1_LSB      = 0;
  localparam int OFF_W         = 18;
  localparam int STOP_GATE_BIT = 21;
  localparam int START_GATE_BIT = 22;
  localparam int CALC_MST_BIT  = 23;
  localparam int CALC_PRT_BIT  = 24;
  localparam int OE_MST_BIT    = 25;
  localparam int OE_PRT_BIT    = 26;
  localparam int RETRIG_BIT    = 27;

  // ----------------
  // Fill level, offset and input power fields
  // ----------------
  localparam int FILL_LSB   = 0;
  localparam int FILL_W     = 8;
  localparam int OFF2_LSB   = 8;
  localparam int ROUTE_BIT  = 26;
  localparam int POWER_BIT  = 27;

  // ----------------
  // Loop divider and timer fields, bus width bit
  // ----------------
  localparam int FDIV_LSB   = 0;
  localparam int FDIV_W     = 8;
  localparam int RDIV_LSB   = 8;
  localparam int RDIV_W     = 3;
  localparam int RESOLUTION_ADJUST_ENABLE_BIT = 11;
  localparam int PHINV_BIT  = 12;
  localparam int OPEN_BIT   = 13;
  localparam int TMR_LSB    = 15;
  localparam int TMR_W      = 13;
  localparam int HALF_BIT   = 4;

  // ----------------
  // Raw hit entry: time, edge, start number, channel
  // ----------------
  localparam int HT_W   = 23;
  localparam int HNUM_W = 8;
  localparam int HCH_W  = 2;
  localparam int HIT_W  = HT_W + 1 + HNUM_W + HCH_W;
  localparam int GAP_W  = 17;
  localparam int LVL_W  = 8;
  localparam logic [7:0] RETRIG_PERIOD = 8'h01;

  typedef enum logic [1:0] {
    MODE_EIGHT  = 2'b00,
    MODE_DUAL   = 2'b01,
    MODE_HIRES  = 2'b10,
    MODE_SINGLE = 2'b11
  } tdcr_mode_t;

endpackage

// ---- src/tdcr_pair_buffer.sv ----
`timescale 1ns/1ps
module tdcr_pair_buffer
  import tdcr_pkg::*;
(
  input  wire logic             clk,       // System clock
  input  wire logic             rstn,      // Async reset, low
  input  wire logic             flush,     // Drop contents
  input  wire logic             inValid,   // Entry offered
  output logic                  inReady,   // Room for entry
  input  wire logic [HIT_W-1:0] inData,    // Entry data
  output logic                  outValid,  // Entry held
  input  wire logic             outReady,  // Consumer takes entry
  output logic [HIT_W-1:0]      outData    // Oldest entry
);

  logic [HIT_W-1:0] mem [2];
  logic             wrPtr_q;
  logic             rdPtr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ---- src/tdcr_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - Stop inputs disabled until first start arrives
// - Start disabled after start, two-channel modes
// - Calc pin high gives master reset
// - Calc pin high gives partial reset instead
// - Output-enable pin low gives master reset
// - Output-enable pin low gives partial reset
// - External retrigger when period one and enabled
// - Primary 18-bit offset added to hit times
// - Fill threshold sets both FIFO level flags
// - Threshold reads back inverted, rest as written
// - Secondary offset used only in dual-edge mode
// - Differential stop routing to odd/even channels, eight-channel mode only
// - Bit 27 powers differential receivers
// - Loop fast and reference divider fields
// - Resolution adjust, phase invert, open loop
// - Measure timer runs programmed count plus one reference periods
// - Bit 4 selects half-width bus
// - Eight-channel result layout time/edge/start/channel
// - Second result register mirrors first layout
// - Gap register reports start interval in eight-channel mode, reads zero otherwise
// - Dual-edge layout 22-bit time plus edge
// - High-res/single layout 23-bit time
module tdcr_regs
  import tdcr_pkg::*;
(
  input  wire logic              clk,             // 20 MHz clock
  input  wire logic              rstn,            // Async reset, low
  input  wire logic              chipSelN,        // Bus chip select
  input  wire logic              readStrobeN,     // Bus read strobe
  input  wire logic              writeStrobeN,    // Bus write strobe
  input  wire logic [ADDR_W-1:0] busAddr,         // Register address
  input  wire logic [DATA_W-1:0] busDataIn,       // Data pins in
  output logic      [DATA_W-1:0] busDataOut_q,    // Data pins out
  output logic                   busDataOe_q,     // Data pins driven
  input  wire logic [1:0]        measureMode,     // Active mode
  input  wire logic              quietMode,       // Quiet operation on
  input  wire logic              oePinUsed,       // Pin used as enable
  input  wire logic              calcTrigPin,     // Calc trigger pin
  input  wire logic              outputEnablePinN, // Enable pin level
  input  wire logic              startPulse,      // Start event
  input  wire logic [7:0]        startRepeatPeriod, // Repeat period
  input  wire logic              refTick,         // Reference clock enable
  input  wire logic              timerStart,      // Timer launch
  input  wire logic              firstHitValid,   // First FIFO push
  output logic                   firstHitReady_q, // First FIFO room
  input  wire logic [HIT_W-1:0]  firstHitData,    // First raw hit
  input  wire logic              secondHitValid,  // Second FIFO push
  output logic                   secondHitReady_q, // Second FIFO room
  input  wire logic [HIT_W-1:0]  secondHitData,   // Second raw hit
  input  wire logic [LVL_W-1:0]  firstFifoLevel,  // First FIFO depth
  input  wire logic [LVL_W-1:0]  secondFifoLevel, // Second FIFO depth
  input  wire logic [GAP_W-1:0]  firstStartGap,   // Measured start gap
  output logic                   stopsDisabled_q, // Stop inputs gated
  output logic                   startDisabled_q, // Start input gated
  output logic                   startRetrigger_q, // Retrigger pulse
  output logic                   masterReset_q,   // Master reset pulse
  output logic                   partialReset_q,  // Partial reset pulse
  output logic                   firstLevelFlag_q, // First fill flag
  output logic                   secondLevelFlag_q, // Second fill flag
  output logic                   oddStopsDiff_q,  // Odd stops routed
  output logic                   evenStopsDiff_q, // Even stops routed
  output logic                   diffRxPower_q,   // Receiver power
  output logic [FDIV_W-1:0]      loopFastDivider_q, // Loop fast divide
  output logic [RDIV_W-1:0]      loopRefDivider_q, // Loop ref divide
  output logic                   resAdjustEnable_q, // Resolution adjust
  output logic                   loopPhaseInvert_q, // Phase inverted
  output logic                   loopOpen_q,      // Regulation cut
  output logic                   timerRunning_q,  // Timer busy
  output logic                   timerDone_q,     // Timer end pulse
  output logic                   halfWidthBus_q   // Half-width mode
);

  // ----------------
  // Register storage and helpers
  // ----------------
  logic [DATA_W-1:0] gateReg_q;
  logic [DATA_W-1:0] fillReg_q;
  logic [DATA_W-1:0] loopReg_q;
  logic [DATA_W-1:0] busReg_q;
  logic [HALF_W-1:0] wrLow_q;
  logic [DATA_W-1:0] rdHold_q;
  logic              halfPhase_q;
  logic              rdPrev_q;
  logic              wrPrev_q;
  logic              startSeen_q;
  logic [TMR_W-1:0]  timerCount_q;
  logic              rdFall;
  logic              wrFall;
  logic              wrCommit;
  logic              rdCapture;
  logic [DATA_W-1:0] wrWord;
  logic [DATA_W-1:0] rdWord;
  logic              startTaken;
  logic              anyReset;
  logic              calcTrig;
  logic              oeTrig;
  logic              pop1;
  logic              pop2;
  logic              buf1Valid;
  logic              buf2Valid;
  logic              buf1Ready;
  logic              buf2Ready;
  logic [HIT_W-1:0]  buf1Data;
  logic [HIT_W-1:0]  buf2Data;
  tdcr_mode_t        mode;

  assign mode = tdcr_mode_t'(measureMode);

  // Offset added at read time; entries keep raw time
  function automatic logic [DATA_W-1:0] fmtResult(input tdcr_mode_t m, input logic [HIT_W-1:0] h,
                                                  input logic [OFF_W-1:0] off);
    logic [HT_W-1:0]   t;
    logic [DATA_W-1:0] w;
    t = h[HT_W-1:0] + HT_W'(off);
    w = ZERO_WORD;
    case (m)
      MODE_EIGHT:  w = {h[HIT_W-1 -: HCH_W], h[HT_W+1 +: HNUM_W], h[HT_W], t[GAP_W-1:0]};
      MODE_DUAL:   w = {5'h00, h[HT_W], t[HT_W-2:0]};
      MODE_HIRES,
      MODE_SINGLE: w = {5'h00, t};
      default:     w = ZERO_WORD;
    endcase
    return w;
  endfunction

  // ----------------
  // Bus strobes
  // ----------------
  // Act on the leading edge of a strobe
  assign rdFall    = !chipSelN && !readStrobeN && rdPrev_q;
  assign wrFall    = !chipSelN && !writeStrobeN && wrPrev_q;
  assign wrCommit  = wrFall && (!halfWidthBus_q || halfPhase_q);
  assign rdCapture = rdFall && (!halfWidthBus_q || !halfPhase_q);
  assign wrWord    = halfWidthBus_q ? {busDataIn[UPPER_W-1:0], wrLow_q} : busDataIn;
  assign pop1      = rdCapture && (busAddr == ADR_RES1) && buf1Valid;
  assign pop2      = rdCapture && (busAddr == ADR_RES2) && buf2Valid;

  always_comb begin
    rdWord = ZERO_WORD;
    case (busAddr)
      ADR_FILL: rdWord = {fillReg_q[DATA_W-1:FILL_W], ~fillReg_q[FILL_W-1:0]};
      ADR_RES1: rdWord = buf1Valid ? fmtResult(mode, buf1Data, gateReg_q[OFF1_LSB +: OFF_W]) : ZERO_WORD;
      ADR_RES2: rdWord = buf2Valid ? fmtResult(mode, buf2Data,
                         (mode == MODE_DUAL) ? fillReg_q[OFF2_LSB +: OFF_W]
                                             : gateReg_q[OFF1_LSB +: OFF_W]) : ZERO_WORD;
      ADR_GAP:  rdWord = (mode == MODE_EIGHT) ? {11'h000, firstStartGap} : ZERO_WORD;
      default:  rdWord = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdPrev_q <= 1'b1;
      wrPrev_q <= 1'b1;
    end else begin
      rdPrev_q <= chipSelN || readStrobeN;
      wrPrev_q <= chipSelN || writeStrobeN;
    end
  end

  // A pair is low half, then high half
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halfPhase_q <= 1'b0;
      wrLow_q     <= 16'h0000;
    end else if (!halfWidthBus_q) begin
      halfPhase_q <= 1'b0;
    end else if (rdFall || wrFall) begin
      halfPhase_q <= ~halfPhase_q;
      if (wrFall && !halfPhase_q) begin
        wrLow_q <= busDataIn[HALF_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gateReg_q <= REG_RESET;
      fillReg_q <= REG_RESET;
      loopReg_q <= REG_RESET;
      busReg_q  <= REG_RESET;
    end else if (wrCommit) begin
      case (busAddr)
        ADR_GATE: gateReg_q <= wrWord;
        ADR_FILL: fillReg_q <= wrWord;
        ADR_LOOP: loopReg_q <= wrWord;
        ADR_BUS:  busReg_q  <= wrWord;
        default:  gateReg_q <= gateReg_q;
      endcase
    end
  end

  // ----------------
  // Read data path
  // ----------------
  // Latch whole word on first half: one pop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdHold_q     <= ZERO_WORD;
      busDataOut_q <= ZERO_WORD;
      busDataOe_q  <= 1'b0;
    end else begin
      busDataOe_q <= !chipSelN && !readStrobeN;
      if (rdCapture) begin
        rdHold_q     <= rdWord;
        busDataOut_q <= halfWidthBus_q ? {12'h000, rdWord[HALF_W-1:0]} : rdWord;
      end else if (rdFall) begin
        busDataOut_q <= {12'h000, 4'h0, rdHold_q[DATA_W-1:HALF_W]};
      end
    end
  end

  tdcr_pair_buffer u_buf1 (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (masterReset_q),
    .inValid  (firstHitValid && firstHitReady_q),
    .inReady  (buf1Ready),
    .inData   (firstHitData),
    .outValid (buf1Valid),
    .outReady (pop1),
    .outData  (buf1Data)
  );

  tdcr_pair_buffer u_buf2 (
    .clk      (clk),
    .rstn     (rstn),
    .flush    (masterReset_q),
    .inValid  (secondHitValid && secondHitReady_q),
    .inReady  (buf2Ready),
    .inData   (secondHitData),
    .outValid (buf2Valid),
    .outReady (pop2),
    .outData  (buf2Data)
  );

  // ----------------
  // Configuration outputs
  // ----------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      firstHitReady_q   <= 1'b0;
      secondHitReady_q  <= 1'b0;
      firstLevelFlag_q  <= 1'b0;
      secondLevelFlag_q <= 1'b0;
      oddStopsDiff_q    <= 1'b0;
      evenStopsDiff_q   <= 1'b0;
      diffRxPower_q     <= 1'b0;
      loopFastDivider_q <= 8'h00;
      loopRefDivider_q  <= 3'h0;
      resAdjustEnable_q <= 1'b0;
      loopPhaseInvert_q <= 1'b0;
      loopOpen_q        <= 1'b0;
      halfWidthBus_q    <= 1'b0;
    end else begin
      // Ready looks ahead so a seen ready always has room
      firstHitReady_q   <= buf1Ready && !(firstHitValid && firstHitReady_q && !pop1 && buf1Valid);
      secondHitReady_q  <= buf2Ready && !(secondHitValid && secondHitReady_q && !pop2 && buf2Valid);
      firstLevelFlag_q  <= firstFifoLevel >= fillReg_q[FILL_LSB +: FILL_W];
      secondLevelFlag_q <= secondFifoLevel >= fillReg_q[FILL_LSB +: FILL_W];
      oddStopsDiff_q    <= (mode == MODE_EIGHT) && fillReg_q[ROUTE_BIT];
      evenStopsDiff_q   <= (mode == MODE_EIGHT) && fillReg_q[ROUTE_BIT];
      diffRxPower_q     <= fillReg_q[POWER_BIT];
      loopFastDivider_q <= loopReg_q[FDIV_LSB +: FDIV_W];
      loopRefDivider_q  <= loopReg_q[RDIV_LSB +: RDIV_W];
      resAdjustEnable_q <= loopReg_q[RESOLUTION_ADJUST_ENABLE_BIT];
      loopPhaseInvert_q <= loopReg_q[PHINV_BIT];
      loopOpen_q        <= loopReg_q[OPEN_BIT];
      halfWidthBus_q    <= busReg_q[HALF_BIT];
    end
  end

  // ----------------
  // Start and stop gating, retrigger
  // ----------------
  assign startTaken = startPulse && !startDisabled_q;
  assign anyReset   = masterReset_q || partialReset_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      startSeen_q      <= 1'b0;
      stopsDisabled_q  <= 1'b0;
      startDisabled_q  <= 1'b0;
      startRetrigger_q <= 1'b0;
    end else begin
      startRetrigger_q <= startTaken && startSeen_q && (startRepeatPeriod == RETRIG_PERIOD)
                          && gateReg_q[RETRIG_BIT];
      if (startTaken) begin
        startSeen_q <= 1'b1;
      end else if (anyReset) begin
        startSeen_q <= 1'b0;
      end
      stopsDisabled_q <= gateReg_q[STOP_GATE_BIT] && !startSeen_q && !startTaken;
      if (startTaken && gateReg_q[START_GATE_BIT] && (mode != MODE_EIGHT)) begin
        startDisabled_q <= 1'b1;
      end else if (anyReset) begin
        startDisabled_q <= 1'b0;
      end
    end
  end

  // ----------------
  // Pin-driven resets
  // ----------------
  assign calcTrig = calcTrigPin && !quietMode;
  assign oeTrig   = !outputEnablePinN && !oePinUsed;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      masterReset_q  <= 1'b0;
      partialReset_q <= 1'b0;
    end else begin
      masterReset_q  <= (calcTrig && gateReg_q[CALC_MST_BIT] && !gateReg_q[CALC_PRT_BIT])
                        || (oeTrig && gateReg_q[OE_MST_BIT]);
      partialReset_q <= (calcTrig && gateReg_q[CALC_PRT_BIT])
                        || (oeTrig && gateReg_q[OE_PRT_BIT] && !gateReg_q[OE_MST_BIT]);
    end
  end

  // ----------------
  // Measurement timer
  // ----------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timerCount_q   <= 13'h0000;
      timerRunning_q <= 1'b0;
      timerDone_q    <= 1'b0;
    end else begin
      timerDone_q <= 1'b0;
      if (timerStart) begin
        timerCount_q   <= loopReg_q[TMR_LSB +: TMR_W];
        timerRunning_q <= 1'b1;
      end else if (timerRunning_q && refTick) begin
        if (timerCount_q == 13'h0000) begin
          timerRunning_q <= 1'b0;
          timerDone_q    <= 1'b1;
        end else begin
          timerCount_q <= timerCount_q - 13'h0001;
        end
      end
    end
  end

endmodule

// ---- verif/tdcr_regs_assertions.sv ----
`timescale 1ns/1ps
module tdcr_regs_assertions
  import tdcr_pkg::*;
(
  input wire logic              clk,               // Clock
  input wire logic              rstn,              // Reset, low
  input wire logic              chipSelN,          // Select
  input wire logic              readStrobeN,       // Read
  input wire logic              writeStrobeN,      // Write
  input wire logic [ADDR_W-1:0] busAddr,           // Address
  input wire logic [DATA_W-1:0] busDataOut_q,      // Read data
  input wire logic              busDataOe_q,       // Pins driven
  input wire logic              calcTrigPin,       // Calc pin
  input wire logic              outputEnablePinN,  // Enable pin
  input wire logic              startPulse,        // Start
  input wire logic [7:0]        startRepeatPeriod, // Period
  input wire logic              refTick,           // Ref tick
  input wire logic              timerDone_q,       // Timer end
  input wire logic              startRetrigger_q,  // Retrigger
  input wire logic              masterReset_q,     // Master
  input wire logic              partialReset_q,    // Partial
  input wire logic              halfWidthBus_q     // Half bus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic readN, busWrite;
  assign readN = chipSelN | readStrobeN;
  assign busWrite = !chipSelN && !writeStrobeN && busAddr == ADR_BUS;

  // ----------------
  // Bus and controls
  // ----------------
  AST_OE_RISE: assert property ($fell(readN) |=> busDataOe_q)
    else $error("read data not driven");
  AST_OE_FALL: assert property ($rose(readN) |=> !busDataOe_q)
    else $error("data pins held after read");
  AST_DATA_HOLD: assert property (!$fell(readN) |=> $stable(busDataOut_q))
    else $error("read data moved without a read");
  AST_HALF_SRC: assert property ($changed(halfWidthBus_q) |-> $past(busWrite) || $past(busWrite, 2))
    else $error("bus width changed without write");
  AST_RETRIG: assert property (startRetrigger_q |-> $past(startPulse) && $past(startRepeatPeriod) == RETRIG_PERIOD)
    else $error("retrigger without cause");
  AST_MASTER_CAUSE: assert property (masterReset_q |-> $past(calcTrigPin) || !$past(outputEnablePinN))
    else $error("master reset without pin");
  AST_PARTIAL_CAUSE: assert property (partialReset_q |-> $past(calcTrigPin) || !$past(outputEnablePinN))
    else $error("partial reset without pin");
  AST_TIMER_END: assert property (timerDone_q |-> $past(refTick) ##1 !timerDone_q)
    else $error("timer end not a tick pulse");

  cover property ($fell(readN));
  cover property (masterReset_q);
  cover property (timerDone_q);
endmodule

// ---- verif/tdcr_host_model.sv ----
`timescale 1ns/1ps
module tdcr_host_model
  import tdcr_pkg::*;
(
  input  wire logic              clk,          // System clock
  output logic                   chipSelN,     // Select, low
  output logic                   readStrobeN,  // Read, low
  output logic                   writeStrobeN, // Write, low
  output logic      [ADDR_W-1:0] busAddr,      // Address
  output logic      [DATA_W-1:0] busDataIn,    // Data to device
  input  wire logic [DATA_W-1:0] busDataOut_q  // Data from device
);
  logic halfMode;

  initial begin
    {chipSelN, readStrobeN, writeStrobeN} = 3'h7;
    {busAddr, busDataIn, halfMode} = '0;
  end

  // ----------------
  // Strobe low over two edges, then a gap
  // ----------------
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    @(negedge clk);
    {chipSelN, readStrobeN, writeStrobeN} = {1'b0, wr, !wr};
    busAddr = a;
    busDataIn = d;
    repeat (2) @(negedge clk);
    q = busDataOut_q;
    {chipSelN, readStrobeN, writeStrobeN} = 3'h7;
    // Released pins show the inverse, never a stale copy
    busDataIn = ~d;
  endtask

  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    logic [DATA_W-1:0] lo, hi;
    if (halfMode) begin
      access(wr, a, {{UPPER_W{1'b0}}, d[HALF_W-1:0]}, lo);
      access(wr, a, {{HALF_W{1'b0}}, d[DATA_W-1:HALF_W]}, hi);
      q = {hi[UPPER_W-1:0], lo[HALF_W-1:0]};
    end else begin
      access(wr, a, d, q);
    end
    if (wr && a == ADR_BUS) halfMode = d[HALF_BIT];
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
  import tdcr_pkg::*;
;
  logic              clk, rstn, chipSelN, readStrobeN, writeStrobeN, quietMode, oePinUsed, busDataOe_q;
  logic              calcTrigPin, outputEnablePinN, startPulse, refTick, timerStart;
  logic [ADDR_W-1:0] busAddr;
  logic [DATA_W-1:0] busDataIn, busDataOut_q;
  logic [1:0]        measureMode, hv;
  wire  [1:0]        hr;
  logic [7:0]        startRepeatPeriod;
  logic [HIT_W-1:0]  hd [2];
  logic [LVL_W-1:0]  firstFifoLevel, secondFifoLevel;
  logic [GAP_W-1:0]  firstStartGap;
  logic              stopsDisabled_q, startDisabled_q, startRetrigger_q, masterReset_q, partialReset_q;
  logic              firstLevelFlag_q, secondLevelFlag_q, oddStopsDiff_q, evenStopsDiff_q, diffRxPower_q;
  logic              resAdjustEnable_q, loopPhaseInvert_q, loopOpen_q, timerRunning_q, timerDone_q, halfWidthBus_q;
  logic [FDIV_W-1:0] loopFastDivider_q;
  logic [RDIV_W-1:0] loopRefDivider_q;
  logic [ADDR_W-1:0] wo [4] = '{ADR_GATE, ADR_LOOP, ADR_BUS, 4'hF};
  int                fails, compares, b, k, got;

  tdcr_regs uut (
    .clk, .rstn, .chipSelN, .readStrobeN, .writeStrobeN, .busAddr, .busDataIn, .busDataOut_q, .busDataOe_q,
    .measureMode, .quietMode, .oePinUsed, .calcTrigPin, .outputEnablePinN, .startPulse, .startRepeatPeriod,
    .refTick, .timerStart, .firstHitValid(hv[0]), .firstHitReady_q(hr[0]), .firstHitData(hd[0]),
    .secondHitValid(hv[1]), .secondHitReady_q(hr[1]), .secondHitData(hd[1]), .firstFifoLevel, .secondFifoLevel,
    .firstStartGap, .stopsDisabled_q, .startDisabled_q, .startRetrigger_q, .masterReset_q, .partialReset_q,
    .firstLevelFlag_q, .secondLevelFlag_q, .oddStopsDiff_q, .evenStopsDiff_q, .diffRxPower_q,
    .loopFastDivider_q, .loopRefDivider_q, .resAdjustEnable_q, .loopPhaseInvert_q, .loopOpen_q,
    .timerRunning_q, .timerDone_q, .halfWidthBus_q
  );

  tdcr_host_model host (.clk, .chipSelN, .readStrobeN, .writeStrobeN, .busAddr, .busDataIn, .busDataOut_q);

  always #25 clk = ~clk;

  // --------------
  // Shared tasks
  // --------------
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] q;
    host.xfer(1'b1, a, d, q);
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] q;
    host.xfer(1'b0, a, ZERO_WORD, q);
    chk(q, exp);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Producer holds its offer until the buffer has room
  task automatic push(input int s, input logic [HIT_W-1:0] d);
    @(negedge clk);
    hv[s] = 1'b1;
    hd[s] = d;
    while (hr[s] !== 1'b1) @(negedge clk);
    @(negedge clk);
    hv[s] = 1'b0;
    hd[s] = ~d;
  endtask

  task automatic print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {quietMode, oePinUsed, calcTrigPin, startPulse, refTick, timerStart, hv, firstFifoLevel, secondFifoLevel} = '0;
    outputEnablePinN = 1'b1;
    measureMode = MODE_EIGHT;
    startRepeatPeriod = 8'h01;
    firstStartGap = 17'h1ABCD;
    hd = '{34'h0, 34'h0};
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    wr(ADR_FILL, 28'hC0123A5);
    rd(ADR_FILL, 28'hC01235A);
    {firstFifoLevel, secondFifoLevel} = 16'hA5A4;
    repeat (2) @(negedge clk);
    chk({firstLevelFlag_q, secondLevelFlag_q, diffRxPower_q, oddStopsDiff_q, evenStopsDiff_q}, 5'h17);
    foreach (wo[i]) rd(wo[i], ZERO_WORD);
    $display("test fill done");
    wr(ADR_LOOP, 28'h001ADC3);
    chk({loopFastDivider_q, loopRefDivider_q, resAdjustEnable_q, loopPhaseInvert_q, loopOpen_q}, {8'hC3, 3'h5, 3'h5});
    got = 0;
    pulse(timerStart);
    chk(timerRunning_q, 1'b1);
    for (k = 1; k < 9 && got == 0; k++) begin
      pulse(refTick);
      if (timerDone_q === 1'b1) got = k;
    end
    chk({timerRunning_q, 27'(got)}, 28'h0000004);
    $display("test loop done");
    wr(ADR_GATE, 28'h0000005);
    push(0, {2'h2, 8'h3C, 1'b1, 23'h000100});
    push(0, {2'h1, 8'h07, 1'b0, 23'h01FFF0});
    chk(hr, 2'h2);
    rd(ADR_RES1, {2'h2, 8'h3C, 1'b1, 17'h00105});
    rd(ADR_RES1, {2'h1, 8'h07, 1'b0, 17'h1FFF5});
    rd(ADR_RES1, ZERO_WORD);
    push(1, {2'h3, 8'hFF, 1'b1, 23'h000010});
    rd(ADR_RES2, {2'h3, 8'hFF, 1'b1, 17'h00015});
    rd(ADR_GAP, {11'h000, 17'h1ABCD});
    measureMode = MODE_DUAL;
    wr(ADR_FILL, 28'h80020A5);
    push(1, {2'h3, 8'hAA, 1'b1, 23'h3FFF00});
    rd(ADR_RES2, {5'h00, 1'b1, 22'h3FFF20});
    push(0, {2'h3, 8'hAA, 1'b0, 23'h000100});
    rd(ADR_RES1, {5'h00, 1'b0, 22'h000105});
    for (k = 2; k < 4; k++) begin
      measureMode = k[1:0];
      push(0, {2'h3, 8'hAA, 1'b1, 23'h400000});
      rd(ADR_RES1, {5'h00, 23'h400005});
    end
    $display("test results done");
    measureMode = MODE_DUAL;
    wr(ADR_GATE, 28'h0600005);
    chk({stopsDisabled_q, startDisabled_q}, 2'h2);
    pulse(startPulse);
    @(negedge clk);
    chk({stopsDisabled_q, startDisabled_q}, 2'h1);
    for (b = 23; b < 27; b++) begin
      wr(ADR_GATE, 28'h0000001 << b);
      for (k = 0; k < 2; k++) begin
        @(negedge clk);
        quietMode = k[0] && b < 25;
        oePinUsed = k[0] && b > 24;
        calcTrigPin = b < 25;
        outputEnablePinN = b < 25;
        @(negedge clk);
        chk({masterReset_q, partialReset_q}, k ? 2'h0 : (b % 2 ? 2'h2 : 2'h1));
        {calcTrigPin, outputEnablePinN, quietMode, oePinUsed} = 4'h4;
      end
    end
    $display("test resets done");
    wr(ADR_GATE, 28'h8000000);
    pulse(startPulse);
    pulse(startPulse);
    chk(startRetrigger_q, 1'b1);
    startRepeatPeriod = 8'h02;
    pulse(startPulse);
    chk(startRetrigger_q, 1'b0);
    $display("test retrigger done");
    wr(ADR_BUS, 28'h0000010);
    chk(halfWidthBus_q, 1'b1);
    wr(ADR_FILL, 28'h8FEDC12);
    rd(ADR_FILL, 28'h8FEDCED);
    $display("test half bus done");
    print_verdict();
  end
endmodule

bind tdcr_regs tdcr_regs_assertions chk_i (
  .clk, .rstn, .chipSelN, .readStrobeN, .writeStrobeN, .busAddr, .busDataOut_q, .busDataOe_q, .calcTrigPin,
  .outputEnablePinN, .startPulse, .startRepeatPeriod, .refTick, .timerDone_q, .startRetrigger_q, .masterReset_q,
  .partialReset_q, .halfWidthBus_q
);
